// [rccr_font_model.sv]
// Font ROM model that answers the controller's segment and single addresses.
`timescale 1ns/1ps
module rccr_font_model (
	input  wire logic          clk_in,
	input  wire logic          ones_in,
	input  rccr_pkg::rccr_rom_t rom_in,
	output logic [4:0]         seg_a_out,
	output logic [4:0]         seg_b_out,
	output logic [1:0]         fifth_out,
	output logic [4:0]         single_out
);
	logic [4:0] float_pat;

	// A deselected ROM floats, so it shows a pattern that moves every cycle.
	// Segment ROMs only drive their four dot bits when selected low.
	// The fifth-bit ROM is always on and returns a pair of bits.
	always_comb begin
		float_pat = {5{clk_in}} ^ rom_in.seg_addr[4:0];
		seg_a_out = ones_in ? 5'h1e : {rom_in.seg_addr[5:2], 1'b0};
		seg_b_out = ones_in ? 5'h1e : {rom_in.seg_addr[7:4], 1'b0};
		if (rom_in.seg_a_cs_n)
			seg_a_out = float_pat;
		if (rom_in.seg_b_cs_n)
			seg_b_out = float_pat;
		fifth_out  = ones_in ? 2'h3 : rom_in.seg_addr[1:0];
		single_out = ones_in ? 5'h1f : rom_in.single_addr[8:4];
	end
endmodule : rccr_font_model

// [rccr_pkg.sv]
// Types shared by the raster character refresh controller.
package rccr_pkg;
	typedef enum logic [1:0] {
		RCCR_RECIRC   = 2'h0,
		RCCR_TRANSFER = 2'h1
	} rccr_phase_t;

	typedef struct packed {
		logic [7:0] seg_addr;
		logic       seg_a_cs_n;
		logic       seg_b_cs_n;
		logic       fifth_cs_n;
		logic       fifth_sel;
		logic [8:0] single_addr;
	} rccr_rom_t;

	typedef struct packed {
		logic page_clk_en;
		logic row_clk_en;
		logic row_from_page;
		logic page_from_row;
	} rccr_mem_t;
endpackage : rccr_pkg

// [rccr_regs.svh]
// Timing and geometry constants for the raster character refresh controller.
`ifndef RCCR_REGS_SVH
`define RCCR_REGS_SVH
`define RCCR_CLK_HZ        40000000
`define RCCR_DOT_W         5
`define RCCR_DOT_MOD       6
`define RCCR_LINES         7
`define RCCR_ROW_INTERVALS 9
`define RCCR_LINE_W        3
`define RCCR_CODE_W        6
`define RCCR_ROW_CHARS     40
`define RCCR_ROWS          12
`define RCCR_SEG_SPLIT     3'h4
`define RCCR_REFRESH_HZ    60
`define RCCR_MIN_REFRESH_HZ 30
`define RCCR_HOLD_MAX_MS   2
`define RCCR_PAGE_MIN_HZ_25C 500
`define RCCR_PAGE_MIN_HZ_70C 3000
`define RCCR_HOLD_MAX_CYC  ((`RCCR_CLK_HZ / 1000) * `RCCR_HOLD_MAX_MS)
`endif

// [rccr_top.sv]
// Raster character refresh controller: counters, memory sequencing, serializer.
// What this block does
// - At row end, route row register output into page store, load next row.
// - Hold page store still while row register recirculates once per dot line.
// - After the last row, reload the first row group and repeat.
// - Refresh full page at least 30 to 35 times a second, 60 Hz preferred; the defaults refresh at about 386 Hz.
// - Insert zero bits between characters when serializing dot lines.
// - Counters make the line address, track dots and spaces, steer memories.
// - Each row takes nine intervals: seven recirculations, two for transfer.
// - During transfer both sections shift at half the character rate.
// - Never leave the page store unclocked longer than 2 msec.
// - Page store clock meets 500 Hz at 25 C and 3 kHz at 70 C.
// - External logic may enter new characters into either section.
// - Multi-ROM address is 6-bit code plus two low line counter bits.
// - Active-low selects: first ROM lines one to four, second five to seven.
// - Fifth-bit ROM always enabled; line counter bit two picks its bit.
// - Single ROM gets 9-bit address and returns five dots in parallel.
// - Dot-and-space counter modulus is six for a five-dot font.
// - Line counter uses seven line states plus two reload states.
`timescale 1ns/1ps
`include "rccr_regs.svh"
module rccr_top #(
	parameter int DOT_CLK_DIV = 4,
	parameter int ROW_CHARS   = `RCCR_ROW_CHARS,
	parameter int ROWS        = `RCCR_ROWS,
	parameter int HOLD_MAX    = `RCCR_HOLD_MAX_CYC
) (
	input  wire logic                     clk_in,
	input  wire logic                     rst_n_in,
	input  wire logic [`RCCR_CODE_W-1:0]  row_code_in,
	input  wire logic [`RCCR_DOT_W-1:0]   seg_a_dots_in,
	input  wire logic [`RCCR_DOT_W-1:0]   seg_b_dots_in,
	input  wire logic [1:0]               fifth_dots_in,
	input  wire logic [`RCCR_DOT_W-1:0]   single_dots_in,
	input  wire logic                     use_single_in,
	input  wire logic                     entry_row_in,
	input  wire logic                     entry_page_in,
	output rccr_pkg::rccr_rom_t           rom_out,
	output rccr_pkg::rccr_mem_t           mem_out,
	output logic [`RCCR_LINE_W-1:0]       line_sel_out,
	output logic                          video_out,
	output logic                          frame_start_out
);
	localparam int CW = $clog2(ROW_CHARS);
	localparam int RW = $clog2(ROWS);

	// Reset release through two flops; only the second copy is used.
	logic rst_meta_reg;
	logic rst_sync_reg;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	wire logic rst_n = rst_sync_reg;

	// Counter state: dot divider, dot/space, character, line, row.
	logic [7:0]              div_reg, div_next;
	logic [2:0]              dot_reg, dot_next;
	logic [CW-1:0]           chr_reg, chr_next;
	logic [3:0]              line_reg, line_next;
	logic [RW-1:0]           row_reg, row_next;
	logic [4:0]              shift_reg, shift_next;
	logic                    half_reg, half_next;
	logic                    video_reg, video_next;
	logic                    frame_reg, frame_next;
	logic [31:0]             hold_reg, hold_next;
	rccr_pkg::rccr_phase_t   phase;
	rccr_pkg::rccr_mem_t     mem_next, mem_reg;
	logic                    dot_tick, chr_end, row_end;
	logic [`RCCR_DOT_W-1:0]  dots;

	assign dot_tick = (div_reg == 8'(DOT_CLK_DIV - 1));
	assign chr_end  = dot_tick && (dot_reg == 3'(`RCCR_DOT_MOD - 1));
	assign row_end  = chr_end && (chr_reg == CW'(ROW_CHARS - 1));
	// Lines 0..6 show dots, 7..8 are the reload gap.
	assign phase = (line_reg < 4'(`RCCR_LINES)) ? rccr_pkg::RCCR_RECIRC
		: rccr_pkg::RCCR_TRANSFER;

	// Dot line assembly from either ROM arrangement.
	always_comb begin
		if (use_single_in)
			dots = single_dots_in;
		else if (line_reg[2])
			dots = {seg_b_dots_in[4:1], fifth_dots_in[1]};
		else
			dots = {seg_a_dots_in[4:1], fifth_dots_in[0]};
	end

	// Next-state logic of the counters and serializer.
	always_comb begin
		div_next   = dot_tick ? 8'h00 : div_reg + 8'h01;
		dot_next   = dot_reg;
		chr_next   = chr_reg;
		line_next  = line_reg;
		row_next   = row_reg;
		shift_next = shift_reg;
		half_next  = half_reg;
		video_next = video_reg;
		frame_next = 1'b0;
		mem_next   = '0;
		hold_next  = hold_reg + 32'h1;
		if (dot_tick) begin
			// Modulus six gives five dots then one space.
			dot_next = chr_end ? 3'h0 : dot_reg + 3'h1;
			// Dot four leaves at once, so only dots three to zero are held.
			if (dot_reg == 3'h0 && phase == rccr_pkg::RCCR_RECIRC)
				shift_next = {dots[3:0], 1'b0};
			else
				shift_next = {shift_reg[3:0], 1'b0};
			// Space slot and reload gap emit zero.
			video_next = (phase == rccr_pkg::RCCR_RECIRC)
				&& (dot_reg != 3'(`RCCR_DOT_MOD - 1))
				&& ((dot_reg == 3'h0) ? dots[4] : shift_reg[4]);
		end
		if (chr_end) begin
			chr_next = row_end ? '0 : chr_reg + CW'(1);
			half_next = ~half_reg;
			if (phase == rccr_pkg::RCCR_RECIRC) begin
				// Page store idle, row register recirculates.
				mem_next.row_clk_en = 1'b1;
			end else if (half_reg) begin
				// Half character rate shift of both sections.
				mem_next.row_clk_en    = 1'b1;
				mem_next.page_clk_en   = 1'b1;
				mem_next.row_from_page = 1'b1;
				mem_next.page_from_row = 1'b1;
			end
			// Outside entry steers data into either section.
			if (entry_row_in)
				mem_next.row_clk_en = 1'b1;
			if (entry_page_in)
				mem_next.page_clk_en = 1'b1;
		end
		if (row_end) begin
			half_next = 1'b0;
			// Nine intervals per row then wrap to line zero.
			line_next = (line_reg == 4'(`RCCR_ROW_INTERVALS - 1))
				? 4'h0 : line_reg + 4'h1;
			if (line_reg == 4'(`RCCR_ROW_INTERVALS - 1)) begin
				// Last row wraps to first group, page repeats.
				row_next   = (row_reg == RW'(ROWS - 1)) ? '0 : row_reg + RW'(1);
				frame_next = (row_reg == RW'(ROWS - 1));
			end
		end
		// Watchdog clock keeps dynamic charge alive.
		if (hold_reg >= 32'(HOLD_MAX - 1) && !mem_next.page_clk_en)
			mem_next.page_clk_en = 1'b1;
		if (mem_next.page_clk_en)
			hold_next = 32'h0;
	end

	// Counter and output registers.
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			div_reg   <= 8'h00;
			dot_reg   <= 3'h0;
			chr_reg   <= '0;
			line_reg  <= 4'h0;
			row_reg   <= '0;
			shift_reg <= 5'h00;
			half_reg  <= 1'b0;
			video_reg <= 1'b0;
			frame_reg <= 1'b0;
			mem_reg   <= '0;
			hold_reg  <= 32'h0;
		end else begin
			div_reg   <= div_next;
			dot_reg   <= dot_next;
			chr_reg   <= chr_next;
			line_reg  <= line_next;
			row_reg   <= row_next;
			shift_reg <= shift_next;
			half_reg  <= half_next;
			video_reg <= video_next;
			frame_reg <= frame_next;
			mem_reg   <= mem_next;
			hold_reg  <= hold_next;
		end
	end

	// ROM addressing: both arrangements driven at once.
	always_comb begin
		rom_out.seg_addr    = {row_code_in, line_reg[1:0]};
		rom_out.seg_a_cs_n  = line_reg[2] | (phase != rccr_pkg::RCCR_RECIRC);
		rom_out.seg_b_cs_n  = ~line_reg[2] | (phase != rccr_pkg::RCCR_RECIRC);
		rom_out.fifth_cs_n  = 1'b0;
		rom_out.fifth_sel   = line_reg[2];
		rom_out.single_addr = {row_code_in, line_reg[2:0]};
	end

	assign mem_out         = mem_reg;
	assign line_sel_out    = line_reg[2:0];
	assign video_out       = video_reg;
	assign frame_start_out = frame_reg;

	// Checks beside the logic.
	property p_line_wrap;
		@(posedge clk_in) disable iff (!rst_n)
		(row_end && line_reg == 4'(`RCCR_ROW_INTERVALS - 1))
		|=> (line_reg == 4'h0);
	endproperty
	a_line_wrap: assert property (p_line_wrap) else $error("line no wrap");
	property p_line_range;
		@(posedge clk_in) disable iff (!rst_n)
		line_reg < 4'(`RCCR_ROW_INTERVALS);
	endproperty
	a_line_range: assert property (p_line_range) else $error("line range");
	property p_page_still;
		@(posedge clk_in) disable iff (!rst_n)
		(phase == rccr_pkg::RCCR_RECIRC && hold_reg < 32'(HOLD_MAX - 2)
		 && !entry_page_in) |=> !mem_reg.page_clk_en;
	endproperty
	a_page_still: assert property (p_page_still) else $error("page moved");
	property p_hold;
		@(posedge clk_in) disable iff (!rst_n) hold_reg < 32'(HOLD_MAX);
	endproperty
	a_hold: assert property (p_hold) else $error("page hold too long");
	property p_space;
		@(posedge clk_in) disable iff (!rst_n)
		(dot_tick && dot_reg == 3'(`RCCR_DOT_MOD - 1)) |=> !video_reg;
	endproperty
	a_space: assert property (p_space) else $error("space not zero");
	property p_dotmod;
		@(posedge clk_in) disable iff (!rst_n)
		dot_reg < 3'(`RCCR_DOT_MOD);
	endproperty
	a_dotmod: assert property (p_dotmod) else $error("dot modulus");
	property p_cs;
		@(posedge clk_in) disable iff (!rst_n)
		!(rom_out.seg_a_cs_n == 1'b0 && rom_out.seg_b_cs_n == 1'b0);
	endproperty
	a_cs: assert property (p_cs) else $error("two selects");
	property p_addr;
		@(posedge clk_in) disable iff (!rst_n)
		rom_out.single_addr[2:0] == line_sel_out;
	endproperty
	a_addr: assert property (p_addr) else $error("line addr");
	property p_xfer;
		@(posedge clk_in) disable iff (!rst_n)
		(chr_end && phase == rccr_pkg::RCCR_TRANSFER && half_reg)
		|=> (mem_reg.page_from_row && mem_reg.row_from_page);
	endproperty
	a_xfer: assert property (p_xfer) else $error("transfer missing");
endmodule : rccr_top

// [rccr_top_tb_top.sv]
// Self-checking bench for the raster character refresh controller.
`timescale 1ns/1ps
module rccr_top_tb_top;
	localparam int DIV = 4;
	localparam int RC  = 4;
	localparam int RW  = 3;
	localparam int HM  = 800;
	localparam int LN  = 6 * RC * DIV;
	logic                clk, rst_n, ones, single, e_row, e_page, mon_pg;
	logic                video, frame;
	logic [5:0]          code;
	logic [4:0]          sa, sb, sg;
	logic [1:0]          fi;
	logic [2:0]          line, last, nx;
	logic [31:0]         seed;
	logic                tr, gap, fix;
	rccr_pkg::rccr_rom_t rom, rom_x;
	rccr_pkg::rccr_mem_t mem;
	int num_errors, check_count, run, r1, r0, pc, rc, idle, fr, ft, nl, got;
	int von, fx, nd;

	rccr_top #(.DOT_CLK_DIV(DIV), .ROW_CHARS(RC), .ROWS(RW), .HOLD_MAX(HM))
		i_rccr_top (.clk_in(clk), .rst_n_in(rst_n), .row_code_in(code),
		.seg_a_dots_in(sa), .seg_b_dots_in(sb), .fifth_dots_in(fi),
		.single_dots_in(sg), .use_single_in(single), .entry_row_in(e_row),
		.entry_page_in(e_page), .rom_out(rom), .mem_out(mem),
		.line_sel_out(line), .video_out(video), .frame_start_out(frame));
	rccr_font_model i_rccr_font_model (.clk_in(clk), .ones_in(ones),
		.rom_in(rom), .seg_a_out(sa), .seg_b_out(sb), .fifth_out(fi),
		.single_out(sg));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// Font addressing expected from the line count and the character code.
	// Both segment ROMs are deselected while the row is being reloaded.
	function automatic rccr_pkg::rccr_rom_t exp_rom(input logic [5:0] c,
		input logic [2:0] l, input logic t);
		exp_rom = '{seg_addr: {c, l[1:0]}, seg_a_cs_n: l[2] | t,
			seg_b_cs_n: !l[2] | t, fifth_cs_n: 1'b0, fifth_sel: l[2],
			single_addr: {c, l}};
	endfunction : exp_rom

	// Dot line the font model returns for a code and line, zero on gap line seven.
	function automatic logic [4:0] exp_dots(input logic [5:0] c,
		input logic [2:0] l, input logic s);
		if (l == 3'h7)
			exp_dots = 5'h00;
		else if (s)
			exp_dots = c[5:1];
		else if (l[2])
			exp_dots = {c[5:2], l[1]};
		else
			exp_dots = {c[3:0], l[0]};
	endfunction : exp_dots

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic summarize();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Watch the outputs each clock; the page store may only move in transfer.
	always @(posedge clk) if (rst_n) begin
		// Line seven and the first interval shown as zero after it are the gap.
		tr = (line == 3'h7) || (line == 3'h0
			&& (last == 3'h7 || (gap && run < LN - 1)));
		rom_x = exp_rom(code, line, tr);
		check("rom", 32'(rom), 32'(rom_x));
		run++;
		idle++;
		ft++;
		if (video)
			von++;
		if (!fix)
			fx = 0;
		if (mem.row_clk_en)
			rc++;
		if (mem.page_clk_en) begin
			pc++;
			check("idle", 32'(idle <= HM + 1), 32'h1);
			idle = 0;
			if (mon_pg)
				check("pgline", 32'(line inside {[1:5]}), 32'h0);
		end
		if (line !== last) begin
			nx = last + 3'h1;
			check("line", 32'(line), 32'(nx));
			if (nl > 0)
				check("dur", run, last == 3'h0 ? 2 * LN : LN);
			if (mon_pg && last inside {[1:5]})
				check("rowclk", rc, RC);
			if (mon_pg && line == 3'h7 && nl > 7)
				check("pages", pc, RC);
			if (fix && fx > 0) begin
				nd = $countones(exp_dots(code, last, single)) * DIV * RC;
				check("vidcnt", von, nd);
			end
			if (line == 3'h7)
				pc = 0;
			if (fix)
				fx++;
			gap = (line == 3'h0 && last == 3'h7);
			von = 0;
			rc = 0;
			run = 0;
			last = line;
			nl++;
		end
		if (frame) begin
			if (fr > 0)
				check("frame", ft, RW * 9 * LN);
			ft = 0;
			fr++;
		end
		if (video)
			r1++;
		else
			r0++;
		if (ones && !video && r1 > 0)
			check("dots", r1, 5 * DIV);
		if (ones && video && r0 > 0)
			check("space", 32'(r0 >= DIV), 32'h1);
		if (video)
			r0 = 0;
		else
			r1 = 0;
	end

	// Solid font first so run lengths are exact, then random codes and dots.
	initial begin
		rst_n = 1'b0;
		ones = 1'b1;
		single = 1'b0;
		e_row = 1'b0;
		e_page = 1'b0;
		mon_pg = 1'b1;
		gap = 1'b0;
		fix = 1'b0;
		code = 6'h00;
		last = 3'h0;
		seed = 32'hf361;
		repeat (4) @(posedge clk);
		#2 rst_n = 1'b1;
		for (int p = 0; p < 4; p++) begin
			ones = (p < 2);
			single = p[0];
			repeat (2 * RW * 9 * LN) begin
				@(posedge clk);
				#2 seed = lfsr(seed);
				code = seed[5:0];
			end
		end
		// Fixed code 6'h21; from the second line on, each line's count of video-on cycles must equal the ones in its dot line times DIV times RC.
		for (int s = 0; s < 2; s++) begin
			@(posedge clk);
			#2 single = s[0];
			code = 6'h21;
			fix = 1'b1;
			repeat (10 * LN) @(posedge clk);
			#2 fix = 1'b0;
		end
		// External entry mid-row must clock the page store at a character end.
		mon_pg = 1'b0;
		for (int i = 0; i < 2000 && line !== 3'h3; i++)
			@(posedge clk);
		if (line !== 3'h3)
			num_errors++;
		else begin
			#2 e_page = 1'b1;
			e_row = 1'b1;
			got = pc;
			repeat (6 * DIV + 2) @(posedge clk);
			#2 e_page = 1'b0;
			e_row = 1'b0;
			check("entry", 32'(pc > got), 32'h1);
			// Row entry in a reload line clocks every character, not every other.
			for (int i = 0; i < 2000 && line !== 3'h7; i++)
				@(posedge clk);
			if (line !== 3'h7)
				num_errors++;
			else begin
				#2 e_row = 1'b1;
				got = rc;
				repeat (3 * 6 * DIV + 1) @(posedge clk);
				#2 e_row = 1'b0;
				check("entry_row", rc - got, 3);
			end
		end
		summarize();
	end
endmodule : rccr_top_tb_top
